// [hdl/dbghas_regblock.sv]
/*
 * hart info, hart mask window select/window and command control/status
 * registers of the debug module, reached over the debug module interface.
 * assumes word-indexed addresses, one-cycle request strobes and a command
 * engine that reports completion with a done pulse and a result code.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dbghas_regs.svh"
module dbghas_regblock import dbghas_pkg::*; #(
	parameter bit HARTINFO_EN = 1'b1,
	parameter logic [3:0] SCRATCH_COUNT = 4'h1,
	parameter bit SHADOW_KIND = 1'b1,
	parameter logic [3:0] SHADOW_SIZE = 4'h2,
	parameter logic [11:0] SHADOW_LOC = 12'h380,
	parameter int NHARTS = 48,
	parameter int SEL_W = 15,
	parameter logic [4:0] PBUF_SIZE = 5'h08,
	parameter logic [3:0] DATA_COUNT = 4'h2,
	parameter bit RELAX_EN = 1'b1
) (
	input wire logic clk, // debug module clock
	input wire logic rst, // module-active reset, high
	input wire logic reqValid, // one-cycle access strobe
	input wire logic reqWrite, // 1 write, 0 read
	input wire logic [6:0] reqAddr, // register index
	input wire logic [31:0] reqWdata, // write data
	output logic [31:0] rspRdata, // read data, held
	output logic rspValid, // answer pulse
	input wire logic [9:0] hartSelLo, // selected hart low bits
	input wire logic [9:0] hartSelHi, // selected hart high bits
	input wire logic cmdDone, // engine finished command
	input wire logic [2:0] cmdDoneErr, // engine result code
	output logic cmdStart, // command accepted pulse
	output logic cmdBusy, // busy copy
	output logic [2:0] cmdErr, // error field copy
	output logic relaxedChecks, // relaxed permission checks
	output logic [19:0] selHart // selected hart index
);
	dbghas_mask_if #(.SEL_W(SEL_W)) mif();

	logic [SEL_W-1:0] winSel_q, winSel_d; // window select
	logic relax_q, relax_d; // relaxed privilege
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [19:0] selHart_q, selHart_d;
	logic [SEL_W-1:0] selMask;
	logic busyW;
	logic [2:0] errW;
	logic startW;
	logic hitCs, hitCmd, hitAuto, hitData, hitPbuf;
	logic violation;

	// address decode helper
	function automatic logic inRange(input logic [6:0] a, input logic [6:0] lo,
		input logic [6:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// hart info word from presets
	function automatic logic [31:0] hartInfoWord();
		logic [31:0] w;
		w = 32'h0000_0000;
		if (HARTINFO_EN) begin
			w[`DBGHAS_HI_SCRATCH_LSB +: 4] = SCRATCH_COUNT;
			w[`DBGHAS_HI_KIND_BIT] = SHADOW_KIND;
			w[`DBGHAS_HI_SIZE_LSB +: 4] = (SHADOW_SIZE > `DBGHAS_SHADOW_SIZE_MAX) ?
				`DBGHAS_SHADOW_SIZE_MAX : SHADOW_SIZE;
			w[`DBGHAS_HI_LOC_LSB +: 12] = SHADOW_LOC;
		end
		return w;
	endfunction

	// tie select bits above what the mask needs
	always_comb begin
		selMask = '0;
		for (int b = 0; b < SEL_W; b++) begin
			selMask[b] = ((1 << b) * `DBGHAS_WORD_BITS) < NHARTS;
		end
	end

	// program buffer size as reported, never above sixteen words
	localparam logic [4:0] PBUF_RPT = (PBUF_SIZE > `DBGHAS_PBUF_MAX) ?
		`DBGHAS_PBUF_MAX : PBUF_SIZE;
	// data count as reported, held between one and twelve words
	localparam logic [3:0] DCOUNT_RPT = (DATA_COUNT < `DBGHAS_DCOUNT_MIN) ?
		`DBGHAS_DCOUNT_MIN : (DATA_COUNT > `DBGHAS_DCOUNT_MAX) ?
		`DBGHAS_DCOUNT_MAX : DATA_COUNT;

	logic wrReq; // write request this cycle
	logic rdReq; // read request this cycle
	logic wrWinSel; // window select written
	logic wrWindow; // window slice written
	logic wrCs; // control/status written
	logic errClr; // status write taken while idle
	logic [31:0] csWordW; // live control/status word

	// split the strobe into read and write requests
	always_comb begin
		wrReq = reqValid && reqWrite;
		rdReq = reqValid && !reqWrite;
	end

	// decode of the accesses that matter to command tracking
	always_comb begin
		hitCs = reqValid && (reqAddr == `DBGHAS_ADDR_CMDCS);
		hitCmd = reqValid && reqWrite && (reqAddr == `DBGHAS_ADDR_COMMAND);
		hitAuto = reqValid && reqWrite && (reqAddr == `DBGHAS_ADDR_AUTOEXEC);
		hitData = reqValid && inRange(reqAddr, `DBGHAS_ADDR_DATA_LO,
			`DBGHAS_ADDR_DATA_LO + {3'h0, DATA_COUNT} - 7'h01);
		hitPbuf = reqValid && (PBUF_SIZE != 5'h00) && inRange(reqAddr,
			`DBGHAS_ADDR_PBUF_LO, `DBGHAS_ADDR_PBUF_LO + {2'h0, PBUF_SIZE} - 7'h01);
		violation = busyW && ((hitCs && reqWrite) || hitAuto || hitData || hitPbuf);
	end

	// register writes steered by the decode
	always_comb begin
		wrWinSel = wrReq && (reqAddr == `DBGHAS_ADDR_WINSEL);
		wrWindow = wrReq && (reqAddr == `DBGHAS_ADDR_WINDOW);
		wrCs = wrReq && hitCs;
		// a status write while running only marks the busy error
		errClr = wrCs && !busyW;
	end

	// live status word; busy, relax and error change at run time
	always_comb begin
		csWordW = 32'h0000_0000;
		csWordW[`DBGHAS_CS_PBUF_LSB +: 5] = PBUF_RPT;
		csWordW[`DBGHAS_CS_BUSY_BIT] = busyW;
		csWordW[`DBGHAS_CS_RELAX_BIT] = relax_q;
		csWordW[`DBGHAS_CS_ERR_LSB +: 3] = errW;
		csWordW[`DBGHAS_CS_DCOUNT_LSB +: 4] = DCOUNT_RPT;
	end

	// busy tracking and sticky error field
	dbghas_cmd_track dbghas_cmd_track_inst (
		.clk(clk),
		.rst(rst),
		.cmdWrite(hitCmd), // command register written
		.busyViolation(violation), // forbidden access while running
		.errClrWe(errClr), // clear only while idle
		.errClrMask(reqWdata[`DBGHAS_CS_ERR_LSB +: 3]), // ones clear bits
		.cmdDone(cmdDone),
		.cmdDoneErr(cmdDoneErr),
		.busy(busyW),
		.err(errW),
		.startPulse(startW)
	);

	// hart array mask, one slice visible at a time
	dbghas_mask_store #(.NHARTS(NHARTS), .SEL_W(SEL_W)) dbghas_mask_store_inst (
		.clk(clk),
		.rst(rst),
		.mif(mif)
	);

	// window port: select from its register, slice data straight from the bus
	assign mif.sel = winSel_q;
	assign mif.wrEn = wrWindow;
	assign mif.wrData = reqWdata;

	// window select keeps only the bits the mask needs
	always_comb begin
		winSel_d = winSel_q;
		if (wrWinSel) begin
			winSel_d = reqWdata[SEL_W-1:0] & selMask;
		end
	end

	// window select register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			winSel_q <= SEL_W'(`DBGHAS_WINSEL_RESET);
		end else begin
			winSel_q <= winSel_d;
		end
	end

	// relax bit follows idle status writes when the option is built in
	always_comb begin
		relax_d = relax_q;
		if (errClr && RELAX_EN) begin
			relax_d = reqWdata[`DBGHAS_CS_RELAX_BIT];
		end
	end

	// relax register; full checks after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			relax_q <= 1'b0;
		end else begin
			relax_q <= relax_d;
		end
	end

	// read mux; a write answers with the last read data still standing
	always_comb begin
		rdata_d = rdata_q;
		if (rdReq) begin
			case (reqAddr)
				// hart info: presets, or all zero when left out
				`DBGHAS_ADDR_HARTINFO: begin
					rdata_d = hartInfoWord();
				end
				// window select, tied bits read zero
				`DBGHAS_ADDR_WINSEL: begin
					rdata_d = 32'({winSel_q});
				end
				// visible mask slice
				`DBGHAS_ADDR_WINDOW: begin
					rdata_d = mif.rdData;
				end
				// command control and status
				`DBGHAS_ADDR_CMDCS: begin
					rdata_d = csWordW;
				end
				// unmapped indices read zero
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// read data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// every request is answered one cycle later
	always_comb begin
		rvalid_d = reqValid;
	end

	// answer strobe register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rvalid_d;
		end
	end

	// selected hart index, joined from its two halves
	always_comb begin
		selHart_d = {hartSelHi, hartSelLo};
	end

	// selected hart register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selHart_q <= 20'h00000;
		end else begin
			selHart_q <= selHart_d;
		end
	end

	// busy copy, one cycle behind the status word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmdBusy <= 1'b0;
		end else begin
			cmdBusy <= busyW;
		end
	end

	// error field copy, one cycle behind the status word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmdErr <= 3'h0;
		end else begin
			cmdErr <= errW;
		end
	end

	// outputs straight from their registers
	assign rspRdata = rdata_q;
	assign rspValid = rvalid_q;
	assign cmdStart = startW;
	assign relaxedChecks = relax_q;
	assign selHart = selHart_q;
endmodule
`default_nettype wire

// [hdl/dbghas_regs.svh]
/*
 * register offsets, field positions, reset values and limits for the hart info,
 * hart mask window and command control/status registers.
 * assumes word-indexed register addresses on the debug module interface.
 */
`ifndef DBGHAS_REGS_SVH
`define DBGHAS_REGS_SVH

// register indices on the debug module interface
`define DBGHAS_ADDR_HARTINFO 7'h12
`define DBGHAS_ADDR_WINSEL 7'h14
`define DBGHAS_ADDR_WINDOW 7'h15
`define DBGHAS_ADDR_CMDCS 7'h16
`define DBGHAS_ADDR_COMMAND 7'h17
`define DBGHAS_ADDR_AUTOEXEC 7'h18
`define DBGHAS_ADDR_DATA_LO 7'h04
`define DBGHAS_ADDR_DATA_HI 7'h0F
`define DBGHAS_ADDR_PBUF_LO 7'h20
`define DBGHAS_ADDR_PBUF_HI 7'h2F

// hart info field positions
`define DBGHAS_HI_SCRATCH_LSB 20
`define DBGHAS_HI_KIND_BIT 16
`define DBGHAS_HI_SIZE_LSB 12
`define DBGHAS_HI_LOC_LSB 0

// command control/status field positions
`define DBGHAS_CS_PBUF_LSB 24
`define DBGHAS_CS_BUSY_BIT 12
`define DBGHAS_CS_RELAX_BIT 11
`define DBGHAS_CS_ERR_LSB 8
`define DBGHAS_CS_DCOUNT_LSB 0

// limits and resets
`define DBGHAS_SHADOW_SIZE_MAX 4'hC
`define DBGHAS_PBUF_MAX 5'h10
`define DBGHAS_DCOUNT_MIN 4'h1
`define DBGHAS_DCOUNT_MAX 4'hC
`define DBGHAS_WINSEL_RESET 15'h0000
`define DBGHAS_WORD_BITS 32

`endif

// [hdl/dbghas_pkg.sv]
/*
 * types shared by the hart info / abstract status register block.
 * assumes the constants header is included by whoever needs numbers.
 */
package dbghas_pkg;

	// error codes held in the sticky error field
	typedef enum logic [2:0] {
		ERR_NONE,
		ERR_BUSY,
		ERR_UNSUPPORTED,
		ERR_EXCEPTION,
		ERR_HART_STATE,
		ERR_BUS,
		ERR_RESERVED,
		ERR_OTHER
	} dbghas_err_type;

	// command tracking states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} dbghas_state_type;

endpackage

// [hdl/dbghas_mask_if.sv]
/*
 * carrier between the register block and its hart mask window store.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface dbghas_mask_if #(parameter int SEL_W = 15);
	logic [SEL_W-1:0] sel; // current window select
	logic wrEn; // write strobe for the visible slice
	logic [31:0] wrData; // data written into the slice
	logic [31:0] rdData; // visible slice, fixed-zero bits cleared
	modport store (input sel, input wrEn, input wrData, output rdData);
	modport ctrl (output sel, output wrEn, output wrData, input rdData);
endinterface
`default_nettype wire

// [hdl/dbghas_mask_store.sv]
/*
 * hart array mask storage, viewed one 32-bit slice at a time.
 * assumes the controller writes only while the window address is hit.
 */
`timescale 1ns/1ns
`default_nettype none
module dbghas_mask_store import dbghas_pkg::*; #(
	parameter int NHARTS = 48,
	parameter int SEL_W = 15
) (
	input wire logic clk, // debug module clock
	input wire logic rst, // asynchronous reset, active high
	dbghas_mask_if.store mif // window access port
);
	localparam int NWORDS = (NHARTS + 31) / 32;

	logic [31:0] mask_q [NWORDS]; // mask words
	logic [31:0] mask_d [NWORDS]; // next mask words

	// which bits of a slice are backed by a real hart
	function automatic logic [31:0] validBits(input logic [SEL_W-1:0] s);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int n = 0; n < 32; n++) begin
			v[n] = ((32 * int'(s)) + n) < NHARTS;
		end
		return v;
	endfunction

	// write into selected slice, only real hart bits stored
	always_comb begin
		for (int w = 0; w < NWORDS; w++) begin
			mask_d[w] = mask_q[w];
			if (mif.wrEn && (int'(mif.sel) == w)) begin
				mask_d[w] = mif.wrData & validBits(mif.sel);
			end
		end
	end

	// register the mask
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int w = 0; w < NWORDS; w++) begin
				mask_q[w] <= 32'h0000_0000;
			end
		end else begin
			mask_q <= mask_d;
		end
	end

	// read view; unbacked positions read zero
	always_comb begin
		mif.rdData = 32'h0000_0000;
		for (int w = 0; w < NWORDS; w++) begin
			if (int'(mif.sel) == w) begin
				mif.rdData = mask_q[w] & validBits(mif.sel);
			end
		end
	end
endmodule
`default_nettype wire

// [hdl/dbghas_cmd_track.sv]
/*
 * busy tracking and sticky error field for abstract commands.
 * assumes the execution engine pulses done once per started command.
 */
`timescale 1ns/1ns
`default_nettype none
module dbghas_cmd_track import dbghas_pkg::*; (
	input wire logic clk, // debug module clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic cmdWrite, // command register write
	input wire logic busyViolation, // forbidden access while busy
	input wire logic errClrWe, // control/status write, not while busy
	input wire logic [2:0] errClrMask, // ones clear error bits
	input wire logic cmdDone, // engine finished
	input wire logic [2:0] cmdDoneErr, // engine result code
	output logic busy, // command running
	output logic [2:0] err, // sticky error field
	output logic startPulse // command accepted
);
	dbghas_state_type state_q, state_d;
	logic [2:0] err_q, err_d;
	logic pend_q, pend_d; // violation seen during this command
	logic start_q, start_d;

	// next state for busy, pending violation and error
	always_comb begin
		state_d = state_q;
		err_d = err_q;
		pend_d = pend_q;
		start_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (errClrWe) begin
					err_d = err_q & ~errClrMask;
				end
				if (cmdWrite && (err_q == ERR_NONE)) begin
					state_d = ST_RUN;
					start_d = 1'b1;
					pend_d = 1'b0;
				end
			end
			ST_RUN: begin
				if (busyViolation || cmdWrite) begin
					pend_d = 1'b1;
				end
				if (cmdDone) begin
					state_d = ST_IDLE;
					pend_d = 1'b0;
					if (err_q == ERR_NONE) begin
						if (pend_q || busyViolation || cmdWrite) begin
							err_d = ERR_BUSY;
						end else begin
							err_d = cmdDoneErr;
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			err_q <= 3'h0;
			pend_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			err_q <= err_d;
			pend_q <= pend_d;
			start_q <= start_d;
		end
	end

	assign busy = (state_q == ST_RUN);
	assign err = err_q;
	assign startPulse = start_q;
endmodule
`default_nettype wire

// [bench/dbghas_props.sv]
/*
 * port assertions for the hart info / command status register block.
 * assumes it is bound onto dbghas_regblock and shares its single clock.
 */
`timescale 1ns/1ns
`default_nettype none
module dbghas_props #(
	parameter logic [31:0] INFO_WORD = 32'h0,
	parameter logic [31:0] CS_FIXED = 32'h0
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic reqValid, // strobe
	input wire logic reqWrite, // write
	input wire logic [6:0] reqAddr, // index
	input wire logic [31:0] rspRdata, // read data
	input wire logic rspValid, // answer
	input wire logic [9:0] hartSelLo, // low index
	input wire logic [9:0] hartSelHi, // high index
	input wire logic cmdDone, // engine done
	input wire logic cmdStart, // start pulse
	input wire logic cmdBusy, // busy copy
	input wire logic [2:0] cmdErr, // error copy
	input wire logic [19:0] selHart // index out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic rdInfo; // hart info read
	logic rdCs; // status read
	logic wrCmd; // command write
	logic wrCs; // status write
	logic [19:0] selCat; // joined index
	assign rdInfo = reqValid && !reqWrite && reqAddr == 7'h12;
	assign rdCs = reqValid && !reqWrite && reqAddr == 7'h16;
	assign wrCmd = reqValid && reqWrite && reqAddr == 7'h17;
	assign wrCs = reqValid && reqWrite && reqAddr == 7'h16;
	assign selCat = {hartSelHi, hartSelLo};
	// status read and its answer
	sequence s_cs_read;
		rdCs ##1 rspValid;
	endsequence
	// accepted command shows busy next cycle
	sequence s_started;
		cmdStart ##1 cmdBusy;
	endsequence
	a_rsp_follows: assert property (reqValid |=> rspValid) else $error("no answer to request");
	a_rsp_caused: assert property (rspValid |-> $past(reqValid)) else $error("stray answer");
	a_start_cause: assert property (cmdStart |-> $past(wrCmd)) else $error("start without write");
	a_busy_rises: assert property (cmdStart |-> s_started) else $error("busy missing");
	a_busy_holds: assert property (cmdBusy && !$past(cmdDone) |=> cmdBusy)
		else $error("busy dropped early");
	a_busy_clears: assert property (cmdDone && cmdBusy |-> ##2 !cmdBusy)
		else $error("busy stuck");
	a_err_clear: assert property (cmdErr == 3'h0 && $past(cmdErr) != 3'h0 |->
		$past(wrCs) || $past(wrCs, 2)) else $error("error cleared alone");
	a_err_set: assert property (cmdErr != 3'h0 && $past(cmdErr) == 3'h0 |->
		$past(cmdDone) || $past(cmdDone, 2)) else $error("error set off completion");
	a_sel_index: assert property (1'b1 |=> selHart == $past(selCat))
		else $error("hart index wrong");
	a_info_value: assert property (rdInfo |=> rspRdata == INFO_WORD)
		else $error("hart info wrong");
	a_cs_fixed: assert property (s_cs_read |-> (rspRdata & 32'hFFFFE0FF) == CS_FIXED)
		else $error("status fixed fields wrong");
endmodule
bind dbghas_regblock dbghas_props #(
	.INFO_WORD(HARTINFO_EN ? {8'h00, SCRATCH_COUNT, 3'h0, SHADOW_KIND, SHADOW_SIZE, SHADOW_LOC}
		: 32'h0),
	.CS_FIXED({3'h0, PBUF_SIZE, 20'h0, DATA_COUNT})
) dbghas_props_inst (.clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
	.reqAddr(reqAddr), .rspRdata(rspRdata), .rspValid(rspValid), .hartSelLo(hartSelLo),
	.hartSelHi(hartSelHi), .cmdDone(cmdDone), .cmdStart(cmdStart), .cmdBusy(cmdBusy),
	.cmdErr(cmdErr), .selHart(selHart));
`default_nettype wire

// [bench/dbghas_dbg_model.sv]
/*
 * debugger stand-in: issues single register requests on the module interface.
 * assumes requests are taken on the rising edge where the strobe is high.
 */
`timescale 1ns/1ns
`default_nettype none
module dbghas_dbg_model (
	input wire logic clk, // clock
	output logic reqValid, // strobe
	output logic reqWrite, // write
	output logic [6:0] reqAddr, // index
	output logic [31:0] reqWdata // write data
);
	// idle levels at time zero
	initial begin
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = 7'h7F;
		reqWdata = 32'h0;
	end
	// raise after an edge, hold through the taking edge, then scramble released lines
	task automatic access(input logic wr, input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		reqValid <= 1'b1;
		reqWrite <= wr;
		reqAddr <= a;
		reqWdata <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		reqAddr <= ~a;
		reqWdata <= ~d;
	endtask
endmodule
`default_nettype wire

// [bench/dbghas_tb_top.sv]
/*
 * self-checking bench for the register block with an engine stand-in.
 * assumes default block parameters: 48 harts, buffer 8, two data words.
 */
`timescale 1ns/1ns
`default_nettype none
module dbghas_tb_top;
	localparam logic [31:0] CS0 = 32'h08000002; // idle status word
	localparam logic [31:0] INFO = 32'h00112380; // configured hart info
	localparam logic [31:0] ALL = 32'hFFFFFFFF; // full compare mask
	logic clk, rst, reqValid, reqWrite, rspValid, cmdDone, cmdStart, cmdBusy, relaxedChecks;
	logic [6:0] reqAddr; // index
	logic [31:0] reqWdata, rspRdata, r, eW, mW; // data and notes
	logic [9:0] hartSelLo, hartSelHi; // hart fields
	logic [2:0] cmdDoneErr, cmdErr, engCode; // codes
	logic [19:0] selHart; // index out
	logic [31:0] expQ[$], mskQ[$]; // expected answers
	logic [6:0] cause[5] = '{7'h16, 7'h17, 7'h18, 7'h04, 7'h20}; // busy violations
	int failCount = 0, samplesChecked = 0, starts = 0, engDelay = 3, n;
	dbghas_regblock dbghas_regblock_inst (.clk(clk), .rst(rst), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspRdata(rspRdata),
		.rspValid(rspValid), .hartSelLo(hartSelLo), .hartSelHi(hartSelHi), .cmdDone(cmdDone),
		.cmdDoneErr(cmdDoneErr), .cmdStart(cmdStart), .cmdBusy(cmdBusy), .cmdErr(cmdErr),
		.relaxedChecks(relaxedChecks), .selHart(selHart));
	logic [31:0] offRdata; // answer of the copy built without hart info
	dbghas_regblock #(.HARTINFO_EN(1'b0)) dbghas_regblock_nohi_inst (.clk(clk), .rst(rst),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.rspRdata(offRdata), .rspValid(), .hartSelLo(hartSelLo), .hartSelHi(hartSelHi),
		.cmdDone(cmdDone), .cmdDoneErr(cmdDoneErr), .cmdStart(), .cmdBusy(), .cmdErr(),
		.relaxedChecks(), .selHart());
	dbghas_dbg_model dbg (.clk(clk), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqWdata(reqWdata));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic reportAndStop();
		if (failCount == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok);
		samplesChecked++;
		if (ok !== 1'b1) begin
			failCount++;
			$display("wrong value at %0t: output mismatch", $time);
		end
	endtask
	// reads note the expected word; writes note an empty mask
	task automatic rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		dbg.access(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		expQ.push_back(32'h0);
		mskQ.push_back(32'h0);
		dbg.access(1'b1, a, d);
	endtask
	// answer watcher: oldest note against each answer
	always @(negedge clk) begin
		if (rspValid === 1'b1 && expQ.size() > 0) begin
			eW = expQ.pop_front();
			mW = mskQ.pop_front();
			if (mW != 32'h0) begin
				samplesChecked++;
				if ((rspRdata & mW) !== (eW & mW)) begin
					failCount++;
					$display("wrong value at %0t: read data %h", $time, rspRdata);
				end
			end
		end
	end
	// engine stand-in: finishes each started command after engDelay cycles
	initial begin
		forever begin
			do @(posedge clk); while (cmdStart !== 1'b1);
			starts++;
			repeat (engDelay) @(posedge clk);
			cmdDone <= 1'b1;
			cmdDoneErr <= engCode;
			@(posedge clk);
			cmdDone <= 1'b0;
			cmdDoneErr <= ~engCode;
		end
	end
	// watchdog far beyond the expected run length
	initial begin
		#2000000;
		failCount++;
		$display("wrong value at %0t: run did not finish", $time);
		reportAndStop();
	end
	initial begin
		void'($urandom(32'h0565));
		rst = 1'b1;
		hartSelLo = 10'h0;
		hartSelHi = 10'h0;
		cmdDone = 1'b0;
		cmdDoneErr = 3'h0;
		engCode = 3'h0;
		r = $urandom();
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(7'h14, 32'h0, ALL);
		rd(7'h16, CS0, ALL);
		repeat (4) begin
			hartSelLo <= 10'($urandom());
			hartSelHi <= 10'($urandom());
			repeat (2) @(posedge clk);
			chk(selHart === {hartSelHi, hartSelLo});
			rd(7'h12, INFO, ALL);
			@(posedge clk);
			chk(offRdata === 32'h0);
		end
		wr(7'h12, r);
		rd(7'h12, INFO, ALL);
		wr(7'h16, 32'hFFFFF0FF);
		rd(7'h16, CS0, ALL);
		rd(7'h13, 32'h0, ALL);
		// window slices: full slice 0, half-backed slice 1
		wr(7'h15, r);
		rd(7'h15, r, ALL);
		wr(7'h14, ALL);
		rd(7'h14, 32'h1, ALL);
		wr(7'h15, ~r);
		rd(7'h15, ~r & 32'h0000FFFF, ALL);
		wr(7'h14, 32'h0);
		rd(7'h15, r, ALL);
		wr(7'h16, 32'h00000800);
		rd(7'h16, CS0 | 32'h800, ALL);
		chk(relaxedChecks === 1'b1);
		wr(7'h16, 32'h0);
		@(posedge clk);
		chk(relaxedChecks === 1'b0);
		// busy violations first, then engine result codes 2 to 7
		for (int k = 0; k < 11; k++) begin
			n = starts;
			engDelay = 10 + $urandom_range(8);
			engCode = (k < 5) ? 3'(k + 2) : 3'(k - 3);
			wr(7'h17, $urandom());
			rd(7'h16, 32'h1000, 32'h1000);
			if (k < 5 && cause[k] > 7'h15) wr(cause[k], 32'h0);
			if (k < 5 && cause[k] < 7'h16) rd(cause[k], 32'h0, 32'h0);
			repeat (24) @(posedge clk);
			chk(cmdErr === ((k < 5) ? 3'h1 : engCode));
			rd(7'h16, CS0 | {21'h0, (k < 5) ? 3'h1 : engCode, 8'h0}, ALL);
			chk(starts == n + 1);
			wr(7'h16, 32'h700);
		end
		// a set error blocks the next command until cleared
		n = starts;
		engDelay = 2;
		wr(7'h17, r);
		repeat (8) @(posedge clk);
		wr(7'h17, r);
		repeat (8) @(posedge clk);
		chk(cmdErr === 3'h7 && cmdBusy === 1'b0);
		chk(starts == n + 1);
		rd(7'h16, CS0 | 32'h700, ALL);
		wr(7'h16, 32'h700);
		rd(7'h16, CS0, ALL);
		repeat (2) @(posedge clk);
		chk(expQ.size() == 0);
		reportAndStop();
	end
endmodule
`default_nettype wire
